/* rtl/prw_pkg.sv */
// constants and types shared by the power, reset and wake control block
package prw_pkg;
   // clock and time base
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned MS_PER_S     = 1000;
   localparam int unsigned CYC_PER_MS   = CLK_HZ / MS_PER_S;
   localparam int unsigned MS_W         = 10;
   // power-good stage and switch pulse delays in ms (least figures of each range)
   localparam logic [9:0] PG1_SLOW_MS   = 10'd300;
   localparam logic [9:0] PG1_FAST_MS   = 10'd200;
   localparam logic [9:0] PG2_NONE_MS   = 10'd0;
   localparam logic [9:0] PG2_SHORT_MS  = 10'd32;
   localparam logic [9:0] PG2_MID_MS    = 10'd96;
   localparam logic [9:0] PG2_LONG_MS   = 10'd250;
   localparam logic [9:0] RETRIG_LOW_MS = 10'd1;
   localparam logic [9:0] PSW_PULSE_MS  = 10'd500;
   // register indexes; byte address is four times the index
   localparam logic [9:0] IDX_MOUSE_KB  = 10'h0e0;
   localparam logic [9:0] IDX_POLICY    = 10'h0e4;
   localparam logic [9:0] IDX_GPIO_RST  = 10'h0e5;
   localparam logic [9:0] IDX_PWR_SEQ   = 10'h0e6;
   localparam logic [9:0] IDX_WAKE_OPT  = 10'h0e7;
   localparam logic [9:0] IDX_LIVE_STAT = 10'h0e8;
   localparam logic [9:0] IDX_WAKE_GEN  = 10'h0f2;
   localparam logic [9:0] IDX_WSTAT_A   = 10'h0f3;
   localparam logic [9:0] IDX_WSTAT_B   = 10'h0f4;
   localparam logic [9:0] IDX_WEN_A     = 10'h0f6;
   localparam logic [9:0] IDX_WEN_B     = 10'h0f7;
   // reset values
   localparam logic [7:0] GPIO_RST_RST  = 8'h00;
   localparam logic [7:0] PWR_SEQ_RST   = 8'h1c;
   localparam logic [7:0] WAKE_OPT_RST  = 8'h00;
   localparam logic [7:0] WAKE_GEN_RST  = 8'h3e;
   localparam logic [7:0] ZERO8         = 8'h00;
   // field positions
   localparam int GPIO_BLK_LSB  = 3;
   localparam int GP25_SEL_BIT  = 2;
   localparam int MOUSE_CMB_BIT = 7;
   localparam int CHS_CLR_BIT   = 5;
   localparam int LAST_ST_BIT   = 4;
   localparam int PG1_SEL_BIT   = 3;
   localparam int PG2_LSB       = 1;
   localparam int RETRIG_BIT    = 0;
   localparam int KD3_BIT       = 7;
   localparam int KD2_BIT       = 6;
   localparam int OSKEY_BIT     = 5;
   localparam int RESTORE_BIT   = 4;
   localparam int WDT_SEL_BIT   = 3;
   localparam int HWM_SEL_BIT   = 0;
   localparam int KB_WAKE_BIT   = 6;
   localparam int MS_RKEY_BIT   = 4;
   localparam int MS_XKEY_BIT   = 1;
   localparam int POLICY_LSB    = 5;
   localparam int GEN_EN_BIT    = 0;
   localparam int NGPIO_GRP     = 5;
   localparam int NWAKE_A       = 7;
   localparam int NWAKE_B       = 6;
   // power-loss policy codes
   localparam logic [1:0] POL_OFF  = 2'h0;
   localparam logic [1:0] POL_ON   = 2'h1;
   localparam logic [1:0] POL_PREV = 2'h2;
   localparam logic [1:0] POL_USER = 2'h3;
   // power-good sequencer states
   typedef enum logic [4:0] {
      PG_IDLE   = 5'h01,
      PG_STAGE1 = 5'h02,
      PG_STAGE2 = 5'h04,
      PG_ON     = 5'h08,
      PG_RETRIG = 5'h10
   } prw_pg_state_t;
endpackage

/* rtl/prw_ctrl.sv */
// power-good sequencing, reset source selection and wake-event control
`timescale 1ns/1ps
// Function
// - gpio group 7..3 bus reset passes when bit is 0, blocked when 1.
// - pins 25..27 reset by bus reset at 0, resume-well reset at 1.
// - writing 1 to intrusion clear bit clears latched status; bit self-clears.
// - keep last-power-state flag: 0 means on, 1 means off.
// - first power-good stage lasts 300ms at select 0, 200ms at select 1.
// - second stage delay: none, 32, 96 or 250 ms per two-bit code.
// - retrigger bit drops power-good low then raises it; bit self-clears.
// - three mouse key bits select which mouse actions wake the system.
// - third keyboard wake key set joins matching when enabled.
// - second keyboard wake key set joins matching when enabled.
// - os key with keyboard wake and option enabled pulses power switch.
// - on power return with policy on and enable set, 0.5s switch pulse.
// - watchdog reset by bus reset at 0, by power-good at 1.
// - hardware monitor reset by power-good at 0, by bus reset at 1.
// - latch seven wake sources in group a bits 6..0; write 1 clears.
// - latch six wake sources in group b bits 5..0; write 1 clears.
// - each wake source has its own enable bit toward wake output.
// - power-loss policy: off, on, previous state, or last-state flag.
module prw_ctrl #(
   parameter int unsigned CYC_PER_MS = prw_pkg::CYC_PER_MS
) (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_n_i,
   // apb slave
   input  wire logic                          psel_i,
   input  wire logic                          penable_i,
   input  wire logic                          pwrite_i,
   input  wire logic [11:0]                   paddr_i,
   input  wire logic [31:0]                   pwdata_i,
   input  wire logic [3:0]                    pstrb_i,
   output logic      [31:0]                   prdata_o,
   output logic                               pready_o,
   output logic                               pslverr_o,
   // power and reset inputs
   input  wire logic                          power_ok_i,
   input  wire logic                          bus_reset_n_i,
   input  wire logic                          resume_well_reset_n_i,
   input  wire logic                          power_restore_i,
   // event inputs, one-cycle pulses
   input  wire logic                          chassis_intrusion_i,
   input  wire logic                          os_key_i,
   input  wire logic [prw_pkg::NWAKE_A-1:0]   wake_src_a_i,
   input  wire logic [prw_pkg::NWAKE_B-1:0]   wake_src_b_i,
   // power-good, power switch and wake event outputs
   output logic                               power_good_first_stage_o,
   output logic                               power_good_second_stage_o,
   output logic                               power_good_out_o,
   output logic                               power_switch_out_n_o,
   output logic                               wake_event_n_o,
   // selected resets
   output logic [prw_pkg::NGPIO_GRP-1:0]      gpio_grp_reset_n_o,
   output logic                               gpio_25_27_reset_n_o,
   output logic                               watchdog_reset_n_o,
   output logic                               hw_monitor_reset_n_o,
   // wake matcher configuration and intrusion status
   output logic [2:0]                         mouse_wake_sel_o,
   output logic                               kb_wake_set_two_en_o,
   output logic                               kb_wake_set_three_en_o,
   output logic                               chassis_intrusion_o
);
   localparam int DIVW = $clog2(CYC_PER_MS + 1);
   localparam logic [DIVW-1:0] DIV_LAST = DIVW'(CYC_PER_MS - 1);

   logic [7:0]                      gpio_rst;
   logic [7:0]                      pwr_seq;
   logic [7:0]                      wake_opt;
   logic [7:0]                      mouse_kb;
   logic [1:0]                      policy;
   logic                            wake_gen_en;
   logic [prw_pkg::NWAKE_A-1:0]     wstat_a;
   logic [prw_pkg::NWAKE_B-1:0]     wstat_b;
   logic [prw_pkg::NWAKE_A-1:0]     wen_a;
   logic [prw_pkg::NWAKE_B-1:0]     wen_b;
   logic                            retrig_req;
   logic                            sys_on;
   prw_pkg::prw_pg_state_t          state;
   prw_pkg::prw_pg_state_t          next_state;
   logic [DIVW-1:0]                 seq_div;
   logic [9:0]                      seq_ms;
   logic [DIVW-1:0]                 psw_div;
   logic [9:0]                      psw_ms;
   logic [9:0]                      pg1_ms;
   logic [9:0]                      pg2_ms;
   logic                            policy_on;
   logic                            pulse_go;
   logic [9:0]                      idx;
   logic                            hit;
   logic                            wr;
   logic [7:0]                      next_rdata;

   // ---------------- apb slave ----------------
   assign idx = paddr_i[11:2];
   always_comb begin
      hit = (paddr_i[1:0] == 2'h0);
      next_rdata = prw_pkg::ZERO8;
      case (idx)
         prw_pkg::IDX_MOUSE_KB:  next_rdata = mouse_kb;
         prw_pkg::IDX_POLICY:    next_rdata = {1'b0, policy, 5'h00};
         prw_pkg::IDX_GPIO_RST:  next_rdata = gpio_rst;
         prw_pkg::IDX_PWR_SEQ:   next_rdata = {pwr_seq[7:1], retrig_req};
         prw_pkg::IDX_WAKE_OPT:  next_rdata = wake_opt;
         prw_pkg::IDX_LIVE_STAT: next_rdata = {3'h0, sys_on,
            power_good_first_stage_o, power_good_second_stage_o,
            power_good_out_o, chassis_intrusion_o};
         prw_pkg::IDX_WAKE_GEN:  next_rdata = {prw_pkg::WAKE_GEN_RST[7:1],
                                               wake_gen_en};
         prw_pkg::IDX_WSTAT_A:   next_rdata = {1'b0, wstat_a};
         prw_pkg::IDX_WSTAT_B:   next_rdata = {2'h0, wstat_b};
         prw_pkg::IDX_WEN_A:     next_rdata = {1'b0, wen_a};
         prw_pkg::IDX_WEN_B:     next_rdata = {2'h0, wen_b};
         default:                hit = 1'b0;
      endcase
   end

   // answer is prepared in the setup cycle so the access phase is one cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end else begin
         pready_o  <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !hit;
         if (psel_i && !penable_i) begin
            prdata_o <= {24'h000000, next_rdata};
         end
      end
   end

   // only byte lane 0 carries register data
   assign wr = psel_i && penable_i && pready_o && pwrite_i &&
               pstrb_i[0] && hit;

   // ---------------- configuration registers ----------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gpio_rst    <= prw_pkg::GPIO_RST_RST;
         pwr_seq     <= prw_pkg::PWR_SEQ_RST;
         wake_opt    <= prw_pkg::WAKE_OPT_RST;
         mouse_kb    <= prw_pkg::ZERO8;
         policy      <= prw_pkg::POL_OFF;
         wake_gen_en <= prw_pkg::WAKE_GEN_RST[prw_pkg::GEN_EN_BIT];
         wen_a       <= '0;
         wen_b       <= '0;
      end else if (wr) begin
         case (idx)
            prw_pkg::IDX_GPIO_RST: gpio_rst <= {pwdata_i[7:2], 2'h0};
            // last-state flag kept; clear and retrigger bits not stored
            prw_pkg::IDX_PWR_SEQ:  pwr_seq  <= {pwdata_i[7], 1'b0, 1'b0,
                                                pwdata_i[4:1], 1'b0};
            prw_pkg::IDX_WAKE_OPT: wake_opt <= {pwdata_i[7:3], 2'h0,
                                                pwdata_i[0]};
            prw_pkg::IDX_MOUSE_KB: mouse_kb <= {1'b0, pwdata_i[6], 1'b0,
                                   pwdata_i[4], 2'h0, pwdata_i[1], 1'b0};
            prw_pkg::IDX_POLICY:
               policy <= pwdata_i[prw_pkg::POLICY_LSB +: 2];
            prw_pkg::IDX_WAKE_GEN:
               wake_gen_en <= pwdata_i[prw_pkg::GEN_EN_BIT];
            prw_pkg::IDX_WEN_A: wen_a <= pwdata_i[prw_pkg::NWAKE_A-1:0];
            prw_pkg::IDX_WEN_B: wen_b <= pwdata_i[prw_pkg::NWAKE_B-1:0];
            default: ;
         endcase
      end
   end

   // ---------------- wake status, set wins over clear ----------------
   // group a latch and write-one clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wstat_a <= '0;
      end else begin
         wstat_a <= (wstat_a & ~((wr && idx == prw_pkg::IDX_WSTAT_A) ?
                     pwdata_i[prw_pkg::NWAKE_A-1:0] : '0)) | wake_src_a_i;
      end
   end

   // group b latch and write-one clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wstat_b <= '0;
      end else begin
         wstat_b <= (wstat_b & ~((wr && idx == prw_pkg::IDX_WSTAT_B) ?
                     pwdata_i[prw_pkg::NWAKE_B-1:0] : '0)) | wake_src_b_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wake_event_n_o <= 1'b1;
      end else begin
         wake_event_n_o <= !(wake_gen_en &&
                             (|(wstat_a & wen_a) || |(wstat_b & wen_b)));
      end
   end

   // intrusion latch; clear bit is a strobe and always reads 0
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         chassis_intrusion_o <= 1'b0;
      end else if (chassis_intrusion_i) begin
         chassis_intrusion_o <= 1'b1;
      end else if (wr && idx == prw_pkg::IDX_PWR_SEQ &&
                   pwdata_i[prw_pkg::CHS_CLR_BIT]) begin
         chassis_intrusion_o <= 1'b0;
      end
   end

   // ---------------- power-good sequencer ----------------
   // first stage delay select
   assign pg1_ms = pwr_seq[prw_pkg::PG1_SEL_BIT] ?
                   prw_pkg::PG1_FAST_MS : prw_pkg::PG1_SLOW_MS;

   always_comb begin
      case (pwr_seq[prw_pkg::PG2_LSB +: 2])
         2'h0:    pg2_ms = prw_pkg::PG2_NONE_MS;
         2'h1:    pg2_ms = prw_pkg::PG2_SHORT_MS;
         2'h2:    pg2_ms = prw_pkg::PG2_MID_MS;
         default: pg2_ms = prw_pkg::PG2_LONG_MS;
      endcase
   end

   always_comb begin
      next_state = state;
      case (state)
         prw_pkg::PG_IDLE:
            if (power_ok_i) next_state = prw_pkg::PG_STAGE1;
         prw_pkg::PG_STAGE1:
            if (!power_ok_i) next_state = prw_pkg::PG_IDLE;
            else if (seq_ms >= pg1_ms) next_state = prw_pkg::PG_STAGE2;
         prw_pkg::PG_STAGE2:
            if (!power_ok_i) next_state = prw_pkg::PG_IDLE;
            else if (seq_ms >= pg2_ms) next_state = prw_pkg::PG_ON;
         prw_pkg::PG_ON:
            if (!power_ok_i) next_state = prw_pkg::PG_IDLE;
            else if (retrig_req) next_state = prw_pkg::PG_RETRIG;
         prw_pkg::PG_RETRIG:
            if (!power_ok_i) next_state = prw_pkg::PG_IDLE;
            else if (seq_ms >= prw_pkg::RETRIG_LOW_MS)
               next_state = prw_pkg::PG_STAGE2;
         default: next_state = prw_pkg::PG_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state                     <= prw_pkg::PG_IDLE;
         power_good_first_stage_o  <= 1'b0;
         power_good_second_stage_o <= 1'b0;
         power_good_out_o          <= 1'b0;
      end else begin
         state                     <= next_state;
         power_good_first_stage_o  <= next_state != prw_pkg::PG_IDLE;
         power_good_second_stage_o <= next_state == prw_pkg::PG_STAGE2 ||
                                      next_state == prw_pkg::PG_ON ||
                                      next_state == prw_pkg::PG_RETRIG;
         power_good_out_o          <= next_state == prw_pkg::PG_ON;
      end
   end

   // stage timer restarts with its divider so every delay is whole ms
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || next_state != state) begin
         seq_div <= '0;
         seq_ms  <= '0;
      end else if (seq_div == DIV_LAST) begin
         seq_div <= '0;
         if (seq_ms != 10'h3ff) seq_ms <= seq_ms + 10'h001;
      end else begin
         seq_div <= seq_div + DIVW'(1);
      end
   end

   // retrigger request, honoured only while power-good is up
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         retrig_req <= 1'b0;
      end else if (wr && idx == prw_pkg::IDX_PWR_SEQ &&
                   pwdata_i[prw_pkg::RETRIG_BIT]) begin
         retrig_req <= 1'b1;
      end else if (state != prw_pkg::PG_ON || next_state != state) begin
         retrig_req <= 1'b0;
      end
   end

   // ---------------- power switch pulse ----------------
   // system state before a loss, frozen at the moment power returns
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sys_on <= 1'b0;
      end else if (!power_restore_i) begin
         sys_on <= power_ok_i;
      end
   end

   always_comb begin
      case (policy)
         prw_pkg::POL_OFF:  policy_on = 1'b0;
         prw_pkg::POL_ON:   policy_on = 1'b1;
         prw_pkg::POL_PREV: policy_on = sys_on;
         default:           policy_on = !pwr_seq[prw_pkg::LAST_ST_BIT];
      endcase
   end

   // restore pulse and os key wake share one pulse timer
   assign pulse_go = (power_restore_i && policy_on &&
                      wake_opt[prw_pkg::RESTORE_BIT]) ||
                     (os_key_i && mouse_kb[prw_pkg::KB_WAKE_BIT] &&
                      wake_opt[prw_pkg::OSKEY_BIT]);

   // a new trigger during a pulse restarts it rather than stacking
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         power_switch_out_n_o <= 1'b1;
         psw_div              <= '0;
         psw_ms               <= '0;
      end else if (pulse_go) begin
         power_switch_out_n_o <= 1'b0;
         psw_div              <= '0;
         psw_ms               <= '0;
      end else if (!power_switch_out_n_o) begin
         if (psw_div == DIV_LAST) begin
            psw_div <= '0;
            psw_ms  <= psw_ms + 10'h001;
            if (psw_ms + 10'h001 >= prw_pkg::PSW_PULSE_MS)
               power_switch_out_n_o <= 1'b1;
         end else begin
            psw_div <= psw_div + DIVW'(1);
         end
      end
   end

   // ---------------- reset source selection ----------------
   genvar g;
   generate
      for (g = 0; g < prw_pkg::NGPIO_GRP; g++) begin : g_grp_rst
         // block bit masks the bus reset for its group
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) gpio_grp_reset_n_o[g] <= 1'b0;
            else gpio_grp_reset_n_o[g] <= bus_reset_n_i ||
                                          gpio_rst[prw_pkg::GPIO_BLK_LSB + g];
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gpio_25_27_reset_n_o <= 1'b0;
         watchdog_reset_n_o   <= 1'b0;
         hw_monitor_reset_n_o <= 1'b0;
      end else begin
         gpio_25_27_reset_n_o <= gpio_rst[prw_pkg::GP25_SEL_BIT] ?
                                 resume_well_reset_n_i : bus_reset_n_i;
         watchdog_reset_n_o   <= wake_opt[prw_pkg::WDT_SEL_BIT] ?
                                 power_good_out_o : bus_reset_n_i;
         hw_monitor_reset_n_o <= wake_opt[prw_pkg::HWM_SEL_BIT] ?
                                 bus_reset_n_i : power_good_out_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mouse_wake_sel_o       <= 3'h0;
         kb_wake_set_two_en_o   <= 1'b0;
         kb_wake_set_three_en_o <= 1'b0;
      end else begin
         mouse_wake_sel_o       <= {pwr_seq[prw_pkg::MOUSE_CMB_BIT],
                                    mouse_kb[prw_pkg::MS_RKEY_BIT],
                                    mouse_kb[prw_pkg::MS_XKEY_BIT]};
         kb_wake_set_two_en_o   <= wake_opt[prw_pkg::KD2_BIT];
         kb_wake_set_three_en_o <= wake_opt[prw_pkg::KD3_BIT];
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_on_retrig;
      state == prw_pkg::PG_ON && retrig_req && power_ok_i;
   endsequence
   sequence s_out_low;
      !power_good_out_o;
   endsequence

   a_wake_a_set_wins: assert property (
      wake_src_a_i[0] |=> wstat_a[0])
      else $error("group a status lost a set");
   a_wake_b_clear: assert property (
      wr && idx == prw_pkg::IDX_WSTAT_B && pwdata_i[0] && !wake_src_b_i[0]
      |=> !wstat_b[0])
      else $error("group b status not cleared");
   a_wake_hold: assert property (
      wstat_a[1] && !(wr && idx == prw_pkg::IDX_WSTAT_A && pwdata_i[1])
      |=> wstat_a[1])
      else $error("status bit dropped without clear");
   a_wake_out_level: assert property (
      wake_event_n_o == !$past(wake_gen_en &&
         (|(wstat_a & wen_a) || |(wstat_b & wen_b))))
      else $error("wake output does not follow enabled status");
   a_retrig_drop: assert property (
      s_on_retrig |=> ##1 s_out_low)
      else $error("retrigger did not drop power-good");
   a_pg2_zero: assert property (
      state == prw_pkg::PG_STAGE2 && power_ok_i &&
      pwr_seq[prw_pkg::PG2_LSB +: 2] == 2'h0 |=> state == prw_pkg::PG_ON)
      else $error("zero second-stage delay not immediate");
   a_pg1_early: assert property (
      state == prw_pkg::PG_STAGE1 && seq_ms < pg1_ms
      |=> !power_good_second_stage_o)
      else $error("second stage rose before first delay");
   a_chassis_clr: assert property (
      chassis_intrusion_o && !chassis_intrusion_i && wr &&
      idx == prw_pkg::IDX_PWR_SEQ && pwdata_i[prw_pkg::CHS_CLR_BIT]
      |=> !chassis_intrusion_o)
      else $error("intrusion status not cleared");
   a_restore_pulse: assert property (
      pulse_go |=> !power_switch_out_n_o [*2])
      else $error("power switch pulse not started");
   a_grp_rst: assert property (
      !bus_reset_n_i && !gpio_rst[prw_pkg::GPIO_BLK_LSB]
      |=> !gpio_grp_reset_n_o[0])
      else $error("group reset not passed");
   a_wdt_src: assert property (
      wake_opt[prw_pkg::WDT_SEL_BIT] |=>
      watchdog_reset_n_o == $past(power_good_out_o))
      else $error("watchdog reset source wrong");
endmodule

/* tb/prw_host.sv */
// host chipset model: supplies system power good and bus reset
`timescale 1ns/1ps
module prw_host (
   // clock, requests from the bench and power good from the block
   input  wire logic clk_i,
   input  wire logic power_on_i,
   input  wire logic bus_reset_req_i,
   input  wire logic power_good_i,
   // toward the block
   output logic      power_ok_o,
   output logic      bus_reset_n_o
);
   // bus reset held until the block reports power good
   always_ff @(posedge clk_i) begin
      power_ok_o    <= power_on_i;
      bus_reset_n_o <= power_good_i & ~bus_reset_req_i;
   end
endmodule

/* tb/prw_ctrl_tb.sv */
// self-checking bench for the power, reset and wake control block
`timescale 1ns/1ps
module prw_ctrl_tb;
   logic        clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic        on = 0, brq = 0, restore = 0, pready, pslverr, serr;
   logic        pok, brst_n, pg1, pg2, pgo, psw_n, wk_n, gp_n, wd_n, hm_n;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic        cin = 0, osk = 0, rw_n = 1, cio, k2, k3;
   logic [6:0]  src_a = '0;
   logic [5:0]  src_b = '0;
   logic [2:0]  msel;
   logic [4:0]  grp_n;
   int          n_fail = 0, checks_done = 0, cyc = 0, n;
   wire  [3:0]  vec = {psw_n, pgo, pg2, pg1};
   prw_host host (.clk_i, .power_on_i(on), .bus_reset_req_i(brq),
      .power_good_i(pgo), .power_ok_o(pok), .bus_reset_n_o(brst_n));
   prw_ctrl #(.CYC_PER_MS(10)) dut (.clk_i, .rst_n_i, .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .power_ok_i(pok),
      .bus_reset_n_i(brst_n), .resume_well_reset_n_i(rw_n),
      .power_restore_i(restore), .chassis_intrusion_i(cin),
      .os_key_i(osk), .wake_src_a_i(src_a), .wake_src_b_i(src_b),
      .power_good_first_stage_o(pg1), .power_good_second_stage_o(pg2),
      .power_good_out_o(pgo), .power_switch_out_n_o(psw_n),
      .wake_event_n_o(wk_n), .gpio_grp_reset_n_o(grp_n),
      .gpio_25_27_reset_n_o(gp_n), .watchdog_reset_n_o(wd_n),
      .hw_monitor_reset_n_o(hm_n), .mouse_wake_sel_o(msel),
      .kb_wake_set_two_en_o(k2), .kb_wake_set_three_en_o(k3),
      .chassis_intrusion_o(cio));
   initial forever #20 clk_i = ~clk_i;
   // ceiling well above the roughly 9000 cycles the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         close_out();
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task rng(input int lo, input int hi);
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask
   task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk_i);
      penable <= 1;
      // no wait count assumed; only the bench ceiling ends a hang
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      r = prdata;
      serr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task waitv(input int b, input logic v);
      n = 0;
      while (vec[b] !== v && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task t_regs;
      apb(0, 10'h0e6, 0); chk(r, 32'h1c);
      apb(0, 10'h0f2, 0); chk(r, 32'h3e);
      apb(0, 10'h0f3, 0); chk(r, 32'h00);
      apb(0, 10'h001, 0); chk(serr, 1'b1);
      apb(1, 10'h0e5, 8'hfc); apb(0, 10'h0e5, 0); chk(r, 32'hfc);
      $display("registers done");
   endtask
   task t_power;
      on <= 1;
      waitv(0, 1);
      waitv(1, 1); rng(1995, 2005);
      waitv(2, 1); rng(955, 965);
      apb(1, 10'h0e6, 8'h1d);
      waitv(2, 0); rng(0, 3);
      waitv(2, 1); rng(960, 985);
      apb(0, 10'h0e6, 0); chk(r, 32'h1c);
      $display("power sequence done");
   endtask
   task t_wake;
      apb(1, 10'h0f2, 8'h01);
      apb(1, 10'h0f6, 8'h01);
      src_a <= 7'h7f;
      src_b <= 6'h3f;
      @(posedge clk_i);
      src_a <= 7'h00;
      src_b <= 6'h00;
      repeat (3) @(posedge clk_i);
      chk(wk_n, 1'b0);
      apb(1, 10'h0f3, 8'h00); apb(0, 10'h0f3, 0); chk(r, 32'h7f);
      apb(1, 10'h0f3, 8'h7f); apb(0, 10'h0f3, 0); chk(r, 32'h00);
      chk(wk_n, 1'b1);
      apb(0, 10'h0f4, 0); chk(r, 32'h3f);
      apb(1, 10'h0f4, 8'h3f); apb(0, 10'h0f4, 0); chk(r, 32'h00);
      $display("wake status done");
   endtask
   task t_resets;
      brq <= 1;
      repeat (4) @(posedge clk_i);
      chk({grp_n, gp_n, wd_n, hm_n}, 8'hfd);
      rw_n <= 0;
      repeat (3) @(posedge clk_i);
      chk({grp_n, gp_n, wd_n, hm_n}, 8'hf9);
      rw_n <= 1;
      apb(1, 10'h0e5, 8'h00);
      apb(1, 10'h0e7, 8'h09);
      repeat (3) @(posedge clk_i);
      chk({grp_n, gp_n, wd_n, hm_n}, 8'h02);
      brq <= 0;
      $display("reset select done");
   endtask
   task t_pulse;
      apb(1, 10'h0e4, 8'h20);
      apb(1, 10'h0e7, 8'h10);
      restore <= 1;
      @(posedge clk_i);
      restore <= 0;
      waitv(3, 0); rng(0, 3);
      waitv(3, 1); rng(4990, 5010);
      apb(1, 10'h0e4, 8'h00);
      restore <= 1;
      @(posedge clk_i);
      restore <= 0;
      repeat (4) @(posedge clk_i);
      chk(psw_n, 1'b1);
      $display("switch pulse done");
   endtask
   task t_misc;
      cin <= 1;
      apb(1, 10'h0e0, 8'h52);
      cin <= 0;
      chk(cio, 1'b1);
      apb(1, 10'h0e6, 8'hbc);
      @(posedge clk_i);
      chk(cio, 1'b0);
      apb(1, 10'h0e7, 8'he0);
      osk <= 1;
      @(posedge clk_i);
      osk <= 0;
      repeat (2) @(posedge clk_i);
      chk({msel, k2, k3, psw_n}, 6'h3e);
      $display("options done");
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1;
      t_regs();
      t_power();
      t_wake();
      t_resets();
      t_pulse();
      t_misc();
      close_out();
   end
endmodule
